//--- rtl/pipeline_stall_defs.svh
`ifndef PIPELINE_STALL_DEFS_SVH
`define PIPELINE_STALL_DEFS_SVH

`define CLOCKS_PER_STATE     2
`define CYCLE_BASE_DEMUX     8'h02
`define CYCLE_BASE_MUX       8'h03
`define CYCLE_WAIT_MAX       8'h0f
`define TRISTATE_MAX         8'h01
`define ROM_READ_ADD         8'h02
`define IND_RAM_ADD          8'h01
`define SFR_AFTER_WRITE_ADD  8'h01
`define STATUS_AFTER_FLAGS   8'h02
`define STACK_AFTER_WRITE    8'h02
`define BRANCH_TEST_ADD      8'h01
`define MIN_STATES           8'h02
`define STD_JUMP_STATES      8'h04
`define CACHE_JUMP_STATES    8'h02
`define MISALIGN_ADD         8'h02

`define OFS_SYSCFG           12'h000
`define OFS_STATUS_REG       12'h004
`define OFS_STACK_PTR        12'h008
`define OFS_MULDIV_CTRL      12'h00c
`define OFS_STALL_INFO       12'h010

`define CYCLE_WAIT_HI        3
`define CYCLE_WAIT_LO        0
`define TRISTATE_BIT         5
`define BUS_TYPE_HI          7
`define BUS_TYPE_LO          6
`define CODE_ENABLE_BIT      10

`define STATUS_REG_RESET     16'h0000
`define STACK_PTR_RESET      16'h0000
`define MULDIV_CTRL_RESET    16'h0000
`define STATUS_REG_MASK      16'hffff
`define STACK_PTR_MASK       16'hffff
`define MULDIV_CTRL_MASK     16'hffff

`endif

//--- rtl/pipeline_stall_pkg.sv
package pipeline_stall_pkg;

    typedef enum logic [1:0] {
        BUS_NONE    = 2'b00,
        BUS_MUX8    = 2'b01,
        BUS_MUX16   = 2'b10,
        BUS_DEMUX16 = 2'b11
    } bus_type_e;

    typedef enum logic [1:0] {
        JUMP_NONE     = 2'b00,
        JUMP_STANDARD = 2'b01,
        JUMP_CACHE    = 2'b10
    } jump_e;

    typedef struct packed {
        logic       romOperandRead;
        logic       directRamRead;
        logic       indirectRamRead;
        logic       autoIncDec;
        logic       sfrRead;
        logic       sfrWrite;
        logic       statusRead;
        logic       flagUpdate;
        logic       statusWrite;
        logic       stackImplicit;
        logic       stackWrite;
        logic       condBranch;
        jump_e      jump;
        logic [3:0] targetAddr;
        logic       targetDouble;
        logic [3:0] nextAddr;
        logic       nextDouble;
        logic       extRead;
        logic       extWrite;
        logic       extWord;
        logic       execExternal;
    } instr_desc_s;

    typedef struct packed {
        logic        valid;
        logic [15:0] data;
    } hw_update_s;

    typedef struct packed {
        logic [1:0]  pinMeta;
        logic [1:0]  pinSync;
        logic [3:0]  cycleWaitField;
        logic        tristateWaitBit;
        bus_type_e   busTypeField;
        logic        onchipCodeMemoryEnable;
        logic [15:0] processorStatusRegister;
        logic [15:0] stackPointer;
        logic [15:0] mulDivControl;
        logic [7:0]  remain;
        logic [7:0]  writeRemain;
        logic [7:0]  lastStall;
        logic        phase;
        logic        prevAutoIncDec;
        logic        prevSfrWrite;
        logic        prevFlagUpdate;
        logic        prevStackWrite;
        logic        prevStatusWrite;
        logic [31:0] rdata;
    } state_s;

endpackage

//--- rtl/pipeline_stall_sfr_timing.sv
// What this block does
// [RULE1] One state is two clock periods; all stalls count whole states.
// [RULE2] Access cycle is 2 or 3 states plus (15-cycle) plus (1-tristate) waits.
// [RULE3] Internal ROM operand read, byte or word, adds two states.
// [RULE4] Register or direct internal RAM reads add nothing.
// [RULE5] Indirect RAM read after auto-increment or decrement adds one state.
// [RULE6] Special register read right after a special register write adds one.
// [RULE7] Status register read right after implicit flag update adds two.
// [RULE8] Implicit stack pointer change after explicit stack write adds two.
// [RULE9] External read on a 16-bit bus adds one access cycle.
// [RULE10] Word read on an 8-bit bus takes two access cycles.
// [RULE11] External write costs one access cycle, always when running externally.
// [RULE12] Internal code posts external writes; visible stall is zero to one cycle.
// [RULE13] Word write on an 8-bit bus takes two access cycles.
// [RULE14] Conditional branch right after status register write adds one state.
// [RULE15] Standard jump takes four states, two more for misaligned double target.
// [RULE16] Cache jump takes two, two more if target and successor misaligned.
// [RULE17] Status, stack pointer, multiply control also take hardware updates.
// [RULE18] Software write wins over simultaneous hardware update.
// [RULE19] Byte write stores addressed byte and clears the other byte.
// [RULE20] Unimplemented bits ignore writes and read zero.
// [RULE21] Bus type and code memory enable load from two pins at reset.
// [RULE22] Bus type: 00 none, 01 mux 8-bit, 10 mux 16-bit, 11 demux 16-bit.
// [RULE23] Hazards only between adjacent instructions; stalls hold the history.
//
// Implementation choices: the APB register port and the register offsets.
`timescale 1ns/1ps
`include "pipeline_stall_defs.svh"

module pipeline_stall_sfr_timing (
    input  wire logic                            clock,
    input  wire logic                            rst,
    input  wire logic                            busConfigPinLow,
    input  wire logic                            busConfigPinHigh,
    input  wire logic                            issueValid,
    input  wire pipeline_stall_pkg::instr_desc_s issueDesc,
    output logic                                 issueReady,
    input  wire pipeline_stall_pkg::hw_update_s  hwStatus,
    input  wire pipeline_stall_pkg::hw_update_s  hwStack,
    input  wire pipeline_stall_pkg::hw_update_s  hwMulDiv,
    output logic [15:0]                          processorStatusRegister,
    output logic [15:0]                          stackPointer,
    output logic [15:0]                          mulDivControl,
    output pipeline_stall_pkg::bus_type_e        busTypeField,
    output logic                                 onchipCodeMemoryEnable,
    output logic [7:0]                           stallStates,
    input  wire logic                            psel,
    input  wire logic                            penable,
    input  wire logic                            pwrite,
    input  wire logic [11:0]                     paddr,
    input  wire logic [31:0]                     pwdata,
    input  wire logic [3:0]                      pstrb,
    output logic [31:0]                          prdata,
    output logic                                 pready,
    output logic                                 pslverr
);

    pipeline_stall_pkg::state_s s;
    pipeline_stall_pkg::state_s next_s;

    logic [7:0]  cycleLen;
    logic [7:0]  wideCost;
    logic        byteBus;
    logic        stateTick;
    logic        swWrite;
    logic        swRead;
    logic        mapped;
    logic [15:0] merged;

    function automatic logic [7:0] cycleStates(
        input pipeline_stall_pkg::bus_type_e bt,
        input logic [3:0]                    cw,
        input logic                          tw
    );
        logic [7:0] base;
        base = (bt == pipeline_stall_pkg::BUS_DEMUX16) ?
            `CYCLE_BASE_DEMUX : `CYCLE_BASE_MUX;
        return base + (`CYCLE_WAIT_MAX - {4'h0, cw})
            + (`TRISTATE_MAX - {7'h00, tw});
    endfunction

    function automatic logic misaligned(
        input logic [3:0] addr
    );
        return addr[1:0] == 2'b10;
    endfunction

    function automatic logic [15:0] byteMerge(
        input logic [1:0]  strb,
        input logic [15:0] data
    );
        logic [15:0] r;
        unique case (strb)
            2'b01:   r = {8'h00, data[7:0]};
            2'b10:   r = {data[15:8], 8'h00};
            default: r = data;
        endcase
        return r;
    endfunction

    // Clock counts oscillator periods, so a state is every second edge
    assign stateTick = s.phase; // [RULE1]

    // Mux bus types get the extra base state
    assign cycleLen = cycleStates(s.busTypeField, s.cycleWaitField,
        s.tristateWaitBit); // [RULE2] [RULE22]
    assign byteBus = s.busTypeField == pipeline_stall_pkg::BUS_MUX8; // [RULE22]

    // Same cost shape for reads and writes
    assign wideCost = (byteBus && issueDesc.extWord) ?
        {cycleLen[6:0], 1'b0} : cycleLen; // [RULE9] [RULE10] [RULE13]

    assign swWrite = psel && penable && pwrite && (pstrb[1:0] != 2'b00);
    assign swRead = psel && !penable;
    assign merged = byteMerge(pstrb[1:0], pwdata[15:0]); // [RULE19]

    assign mapped = (paddr == `OFS_SYSCFG) || (paddr == `OFS_STATUS_REG) ||
        (paddr == `OFS_STACK_PTR) || (paddr == `OFS_MULDIV_CTRL) ||
        (paddr == `OFS_STALL_INFO);

    always_comb begin
        logic [7:0] add;
        logic       idle;
        add = 8'h00;
        idle = s.remain == 8'h00;
        next_s = s;
        next_s.pinMeta = {busConfigPinHigh, busConfigPinLow};
        next_s.pinSync = s.pinMeta;
        next_s.phase = ~s.phase;

        if (stateTick) begin
            if (s.remain != 8'h00) begin
                next_s.remain = s.remain - 8'h01;
            end
            if (s.writeRemain != 8'h00) begin
                next_s.writeRemain = s.writeRemain - 8'h01;
            end
        end

        if (issueValid && idle) begin
            if (issueDesc.romOperandRead) begin
                add = add + `ROM_READ_ADD; // [RULE3]
            end
            // Direct and register operands never stall [RULE4]
            if (issueDesc.indirectRamRead && s.prevAutoIncDec) begin
                add = add + `IND_RAM_ADD; // [RULE5]
            end
            if (issueDesc.sfrRead && s.prevSfrWrite) begin
                add = add + `SFR_AFTER_WRITE_ADD; // [RULE6]
            end
            if (issueDesc.statusRead && s.prevFlagUpdate) begin
                add = add + `STATUS_AFTER_FLAGS; // [RULE7]
            end
            if (issueDesc.stackImplicit && s.prevStackWrite) begin
                add = add + `STACK_AFTER_WRITE; // [RULE8]
            end
            if (issueDesc.condBranch && s.prevStatusWrite) begin
                add = add + `BRANCH_TEST_ADD; // [RULE14]
            end

            // Figures beyond the two-state minimum
            unique case (issueDesc.jump)
                pipeline_stall_pkg::JUMP_NONE: begin
                end
                pipeline_stall_pkg::JUMP_STANDARD: begin
                    add = add + (`STD_JUMP_STATES - `MIN_STATES); // [RULE15]
                    if (issueDesc.targetDouble &&
                        misaligned(issueDesc.targetAddr)) begin
                        add = add + `MISALIGN_ADD; // [RULE15]
                    end
                end
                pipeline_stall_pkg::JUMP_CACHE: begin
                    add = add + (`CACHE_JUMP_STATES - `MIN_STATES); // [RULE16]
                    if (issueDesc.targetDouble &&
                        misaligned(issueDesc.targetAddr) &&
                        issueDesc.nextDouble &&
                        misaligned(issueDesc.nextAddr)) begin
                        add = add + `MISALIGN_ADD; // [RULE16]
                    end
                end
                default: begin
                end
            endcase

            // A posted write still on the bus delays the next external read or write
            if (issueDesc.extRead || issueDesc.extWrite) begin
                add = add + s.writeRemain; // [RULE12]
            end
            if (issueDesc.extRead) begin
                add = add + wideCost; // [RULE9] [RULE10]
            end
            if (issueDesc.extWrite) begin
                if (issueDesc.execExternal) begin
                    add = add + wideCost; // [RULE11] [RULE13]
                    next_s.writeRemain = 8'h00;
                end else begin
                    next_s.writeRemain = wideCost; // [RULE12] [RULE13]
                end
            end else if (issueDesc.extRead) begin
                next_s.writeRemain = 8'h00;
            end

            next_s.remain = add;
            next_s.lastStall = add;
            // History moves only on issue, not during stall states
            next_s.prevAutoIncDec = issueDesc.autoIncDec; // [RULE23]
            next_s.prevSfrWrite = issueDesc.sfrWrite; // [RULE23]
            next_s.prevFlagUpdate = issueDesc.flagUpdate; // [RULE23]
            next_s.prevStackWrite = issueDesc.stackWrite; // [RULE23]
            next_s.prevStatusWrite = issueDesc.statusWrite; // [RULE23]
        end

        // Hardware first, software after so it overrides
        if (hwStatus.valid) begin
            next_s.processorStatusRegister =
                hwStatus.data & `STATUS_REG_MASK; // [RULE17]
        end
        if (hwStack.valid) begin
            next_s.stackPointer = hwStack.data & `STACK_PTR_MASK; // [RULE17]
        end
        if (hwMulDiv.valid) begin
            next_s.mulDivControl = hwMulDiv.data & `MULDIV_CTRL_MASK; // [RULE17]
        end

        if (swWrite) begin
            unique case (paddr)
                `OFS_SYSCFG: begin
                    next_s.cycleWaitField =
                        merged[`CYCLE_WAIT_HI:`CYCLE_WAIT_LO]; // [RULE19]
                    next_s.tristateWaitBit = merged[`TRISTATE_BIT];
                    // Bus type frozen once an external bus is chosen
                    if (s.busTypeField == pipeline_stall_pkg::BUS_NONE) begin
                        next_s.busTypeField = pipeline_stall_pkg::bus_type_e'(
                            merged[`BUS_TYPE_HI:`BUS_TYPE_LO]);
                    end
                end
                `OFS_STATUS_REG: begin
                    next_s.processorStatusRegister =
                        merged & `STATUS_REG_MASK; // [RULE18] [RULE19]
                end
                `OFS_STACK_PTR: begin
                    next_s.stackPointer = merged & `STACK_PTR_MASK; // [RULE18]
                end
                `OFS_MULDIV_CTRL: begin
                    next_s.mulDivControl = merged & `MULDIV_CTRL_MASK; // [RULE18]
                end
                default: begin
                end
            endcase
        end

        // Read data is captured in the setup cycle
        if (swRead) begin
            next_s.rdata = 32'h00000000; // [RULE20]
            unique case (paddr)
                `OFS_SYSCFG: begin
                    next_s.rdata[`CYCLE_WAIT_HI:`CYCLE_WAIT_LO] =
                        s.cycleWaitField;
                    next_s.rdata[`TRISTATE_BIT] = s.tristateWaitBit;
                    next_s.rdata[`BUS_TYPE_HI:`BUS_TYPE_LO] = s.busTypeField;
                    next_s.rdata[`CODE_ENABLE_BIT] = s.onchipCodeMemoryEnable;
                end
                `OFS_STATUS_REG: begin
                    next_s.rdata[15:0] = s.processorStatusRegister;
                end
                `OFS_STACK_PTR: begin
                    next_s.rdata[15:0] = s.stackPointer;
                end
                `OFS_MULDIV_CTRL: begin
                    next_s.rdata[15:0] = s.mulDivControl;
                end
                `OFS_STALL_INFO: begin
                    next_s.rdata = {cycleLen, s.writeRemain, s.remain,
                        s.lastStall};
                end
                default: begin
                end
            endcase
        end

        // Reset is synchronous, so the synchronised pins may load here
        if (rst) begin
            next_s = '0;
            next_s.pinMeta = {busConfigPinHigh, busConfigPinLow};
            next_s.pinSync = s.pinMeta;
            next_s.busTypeField =
                pipeline_stall_pkg::bus_type_e'(s.pinSync); // [RULE21]
            next_s.onchipCodeMemoryEnable = s.pinSync == 2'b00; // [RULE21]
            next_s.processorStatusRegister = `STATUS_REG_RESET;
            next_s.stackPointer = `STACK_PTR_RESET;
            next_s.mulDivControl = `MULDIV_CTRL_RESET;
        end
    end

    always_ff @(posedge clock) begin
        s <= next_s;
    end

    assign issueReady = !rst && (s.remain == 8'h00);
    assign processorStatusRegister = s.processorStatusRegister;
    assign stackPointer = s.stackPointer;
    assign mulDivControl = s.mulDivControl;
    assign busTypeField = s.busTypeField;
    assign onchipCodeMemoryEnable = s.onchipCodeMemoryEnable;
    assign stallStates = s.lastStall;
    assign prdata = s.rdata;
    assign pready = psel && penable;
    assign pslverr = psel && penable && !mapped;

endmodule

//--- verification/pipeline_stall_assertions.sv
`timescale 1ns/1ps
module pipeline_stall_checker (
    input wire logic                            clock,
    input wire logic                            rst,
    input wire logic                            busConfigPinLow,
    input wire logic                            busConfigPinHigh,
    input wire logic                            issueValid,
    input wire pipeline_stall_pkg::instr_desc_s issueDesc,
    input wire logic                            issueReady,
    input wire pipeline_stall_pkg::hw_update_s  hwStatus,
    input wire pipeline_stall_pkg::hw_update_s  hwStack,
    input wire logic [15:0]                     processorStatusRegister,
    input wire logic [15:0]                     stackPointer,
    input wire pipeline_stall_pkg::bus_type_e   busTypeField,
    input wire logic                            onchipCodeMemoryEnable,
    input wire logic [7:0]                      stallStates,
    input wire logic                            psel,
    input wire logic                            penable,
    input wire logic                            pwrite,
    input wire logic [11:0]                     paddr,
    input wire logic [31:0]                     pwdata,
    input wire logic [3:0]                      pstrb,
    input wire logic [31:0]                     prdata,
    input wire logic                            pslverr
);
    pipeline_stall_pkg::instr_desc_s prevDesc;
    logic                            taken;
    logic                            swWrite;
    assign taken   = issueValid && issueReady;
    assign swWrite = psel && penable && pwrite;
    // History follows issue order only, so stall cycles never age a hazard
    always_ff @(posedge clock) begin
        if (rst) begin
            prevDesc <= '0;
        end else if (taken) begin
            prevDesc <= issueDesc;
        end
    end
    default clocking dc @(posedge clock);
    endclocking
    default disable iff (rst);
    a_one_state_hold: assert property (taken ##1 stallStates == 8'h01 |->
        !issueReady ##[1:2] issueReady) else $error("one-state stall length wrong");
    a_rom_read_two: assert property (taken && issueDesc.romOperandRead |=>
        stallStates >= 8'h02) else $error("rom operand read stall too short");
    a_indirect_after_inc: assert property (taken && issueDesc.indirectRamRead
        && prevDesc.autoIncDec |=> stallStates >= 8'h01) else $error("indirect stall missing");
    a_status_after_flags: assert property (taken && issueDesc.statusRead
        && prevDesc.flagUpdate |=> stallStates >= 8'h02) else $error("status read stall short");
    a_stack_after_write: assert property (taken && issueDesc.stackImplicit
        && prevDesc.stackWrite |=> stallStates >= 8'h02) else $error("stack stall short");
    a_jump_std_min: assert property (taken &&
        issueDesc.jump == pipeline_stall_pkg::JUMP_STANDARD |=> stallStates >= 8'h02)
        else $error("standard jump stall short");
    a_hw_update_lands: assert property (hwStack.valid && !psel |=>
        stackPointer == $past(hwStack.data)) else $error("hardware stack update lost");
    a_sw_beats_hw: assert property (swWrite && paddr == 12'h004 && pstrb[1:0] == 2'b11
        && hwStatus.valid |=> processorStatusRegister == $past(pwdata[15:0]))
        else $error("hardware update beat software write");
    a_byte_clears_high: assert property (swWrite && paddr == 12'h008
        && pstrb[1:0] == 2'b01 |=> stackPointer == {8'h00, $past(pwdata[7:0])})
        else $error("byte write kept other byte");
    a_syscfg_reserved: assert property (psel && penable && !pwrite && paddr == 12'h000
        |-> prdata[31:11] == 21'h0 && prdata[9:8] == 2'b00 && prdata[4] == 1'b0)
        else $error("reserved config bit not zero");
    a_bus_type_load: assert property ($fell(rst) |->
        busTypeField == {busConfigPinHigh, busConfigPinLow} &&
        onchipCodeMemoryEnable == !(busConfigPinHigh || busConfigPinLow))
        else $error("bus type not loaded from pins");
    c_ext_read: cover property (taken && issueDesc.extRead);
    c_long_stall: cover property (taken ##1 stallStates > 8'h10);
    c_unmapped: cover property (psel && penable && pslverr);
endmodule

bind pipeline_stall_sfr_timing pipeline_stall_checker i_chk (
    .clock(clock), .rst(rst), .busConfigPinLow(busConfigPinLow),
    .busConfigPinHigh(busConfigPinHigh), .issueValid(issueValid), .issueDesc(issueDesc),
    .issueReady(issueReady), .hwStatus(hwStatus), .hwStack(hwStack),
    .processorStatusRegister(processorStatusRegister), .stackPointer(stackPointer),
    .busTypeField(busTypeField), .onchipCodeMemoryEnable(onchipCodeMemoryEnable),
    .stallStates(stallStates), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pslverr(pslverr)
);

//--- verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic                            clock = 1'b0;
    logic                            rst = 1'b1;
    logic                            pinLow = 1'b0;
    logic                            pinHigh = 1'b0;
    logic                            issueValid = 1'b0;
    pipeline_stall_pkg::instr_desc_s issueDesc = '0;
    pipeline_stall_pkg::instr_desc_s prevDesc = '0;
    pipeline_stall_pkg::instr_desc_s d;
    pipeline_stall_pkg::hw_update_s  hwStatus = '0;
    pipeline_stall_pkg::hw_update_s  hwStack = '0;
    pipeline_stall_pkg::hw_update_s  hwMulDiv = '0;
    pipeline_stall_pkg::bus_type_e   busType;
    logic                            issueReady;
    logic                            codeEn;
    logic                            psel = 1'b0;
    logic                            penable = 1'b0;
    logic                            pwrite = 1'b0;
    logic                            pready;
    logic                            pslverr;
    logic                            e;
    logic                            tw;
    logic [1:0]                      bt;
    logic [3:0]                      cw;
    logic [3:0]                      pstrb = '0;
    logic [7:0]                      stallStates;
    logic [11:0]                     paddr = '0;
    logic [15:0]                     statusReg;
    logic [15:0]                     stackPtr;
    logic [15:0]                     mulDiv;
    logic [31:0]                     pwdata = '0;
    logic [31:0]                     prdata;
    logic [31:0]                     r;
    logic [31:0]                     v;
    int                              n_fail = 0;
    int                              checked = 0;
    int                              cycles = 0;
    int                              seed = 31;

    pipeline_stall_sfr_timing i_dut (
        .clock(clock), .rst(rst), .busConfigPinLow(pinLow), .busConfigPinHigh(pinHigh),
        .issueValid(issueValid), .issueDesc(issueDesc), .issueReady(issueReady),
        .hwStatus(hwStatus), .hwStack(hwStack), .hwMulDiv(hwMulDiv),
        .processorStatusRegister(statusReg), .stackPointer(stackPtr), .mulDivControl(mulDiv),
        .busTypeField(busType), .onchipCodeMemoryEnable(codeEn), .stallStates(stallStates),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr)
    );

    always #10 clock = ~clock;

    task automatic complete_run();
        if (n_fail == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    always @(posedge clock) begin
        cycles++;
        if (cycles == 60000) begin
            n_fail++;
            complete_run();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t mismatch got %h exp %h", $time, got, exp);
        end
    endtask

    function automatic logic [7:0] expCost(input pipeline_stall_pkg::instr_desc_s x);
        logic [7:0] a;
        logic [7:0] c;
        a = (bt == 2'b11 ? 8'h02 : 8'h03) + (8'h0f - {4'h0, cw}) + (8'h01 - {7'h0, tw});
        c = x.romOperandRead ? 8'h02 : 8'h00;
        c += (x.indirectRamRead && prevDesc.autoIncDec) ? 8'h01 : 8'h00;
        c += (x.sfrRead && prevDesc.sfrWrite) ? 8'h01 : 8'h00;
        c += (x.statusRead && prevDesc.flagUpdate) ? 8'h02 : 8'h00;
        c += (x.stackImplicit && prevDesc.stackWrite) ? 8'h02 : 8'h00;
        c += (x.condBranch && prevDesc.statusWrite) ? 8'h01 : 8'h00;
        if (x.jump == pipeline_stall_pkg::JUMP_STANDARD) begin
            c += (x.targetDouble && x.targetAddr[1:0] == 2'b10) ? 8'h04 : 8'h02;
        end
        if (x.jump == pipeline_stall_pkg::JUMP_CACHE && x.targetDouble && x.nextDouble &&
            x.targetAddr[1:0] == 2'b10 && x.nextAddr[1:0] == 2'b10) begin
            c += 8'h02;
        end
        a = (x.extWord && bt == 2'b01) ? a << 1 : a;
        c += x.extRead ? a : 8'h00;
        c += (x.extWrite && x.execExternal) ? a : 8'h00;
        return c;
    endfunction

    task automatic issue(input pipeline_stall_pkg::instr_desc_s x);
        logic [7:0] ex;
        ex = expCost(x);
        issueValid <= 1'b1;
        issueDesc  <= x;
        @(posedge clock);
        while (issueReady !== 1'b1) begin
            @(posedge clock);
        end
        issueValid <= 1'b0;
        prevDesc = x;
        @(posedge clock);
        check({24'h0, stallStates}, {24'h0, ex});
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] x,
                       input logic [3:0] s, input logic hw);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= x;
        pstrb  <= s;
        @(posedge clock);
        penable  <= 1'b1;
        hwStatus <= '{hw, x[31:16]};
        hwStack  <= '{hw, x[31:16]};
        @(posedge clock);
        while (pready !== 1'b1) begin
            @(posedge clock);
        end
        r = prdata;
        e = pslverr;
        psel     <= 1'b0;
        penable  <= 1'b0;
        hwStatus <= '0;
        hwStack  <= '0;
        @(posedge clock);
    endtask

    initial begin
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        for (int b = 0; b < 4; b++) begin
            bt = b[1:0];
            {pinHigh, pinLow} <= bt;
            rst <= 1'b1;
            // Pins need two sync flops plus a load edge inside reset
            repeat (4) @(posedge clock);
            rst <= 1'b0;
            prevDesc = '0;
            @(posedge clock);
            check({30'h0, busType}, {30'h0, bt});
            check({31'h0, codeEn}, {31'h0, bt == 2'b00});
            v = $random(seed);
            cw = v[3:0];
            tw = v[5];
            apb(1'b1, 12'h000, {v[31:8], bt, v[5:0]}, 4'hf, 1'b0);
            apb(1'b0, 12'h000, 32'h0, 4'h0, 1'b0);
            check(r, {21'h0, bt == 2'b00, 2'b00, bt, tw, 1'b0, cw});
            apb(1'b1, 12'h004, v, 4'h3, 1'b1);
            apb(1'b0, 12'h004, 32'h0, 4'h0, 1'b0);
            check(r, {16'h0, v[15:0]});
            apb(1'b1, 12'h008, v, 4'h1, 1'b1);
            apb(1'b0, 12'h008, 32'h0, 4'h0, 1'b0);
            check(r, {24'h0, v[7:0]});
            apb(1'b0, 12'h020, 32'h0, 4'h0, 1'b0);
            check(r, 32'h0);
            check({31'h0, e}, 32'h1);
            hwStatus <= '{1'b1, v[15:0]};
            hwStack  <= '{1'b1, v[31:16]};
            hwMulDiv <= '{1'b1, ~v[15:0]};
            @(posedge clock);
            hwStatus <= '0;
            hwStack  <= '0;
            hwMulDiv <= '0;
            @(posedge clock);
            check({statusReg, stackPtr}, {v[15:0], v[31:16]});
            check({16'h0, mulDiv}, {16'h0, ~v[15:0]});
            d = '0;
            d.autoIncDec = 1'b1;
            issue(d);
            d = '0;
            d.indirectRamRead = 1'b1;
            issue(d);
            d = '0;
            d.flagUpdate = 1'b1;
            issue(d);
            d = '0;
            issue(d);
            d.statusRead = 1'b1;
            issue(d);
            d = '0;
            d.extWrite = 1'b1;
            issue(d);
            // Posted write credit is not modelled, so let it drain first
            repeat (100) @(posedge clock);
            repeat (40) begin
                v = $random(seed);
                d = v[27:0];
                d.extWrite = d.extWrite & d.execExternal;
                issue(d);
            end
        end
        complete_run();
    end
endmodule
